// ### twi_map.vh
`ifndef TWI_MAP_VH
`define TWI_MAP_VH

// Register indices; byte address is four times the index
`define IDX_CONTROL       10'h0a5
`define IDX_OWN_ADDRESS   10'h0a6
`define IDX_BYTE_BUFFER   10'h0a7
`define IDX_FUNC_SELECT   10'h0a8

// Control register fields
`define CTL_PORT_ENABLE   7
`define CTL_EVENT_FLAG    6
`define CTL_GC_HIT        4
`define CTL_ACCEPT_ACK    3

// Own address register fields
`define OA_GC_ENABLE      0

// Reset values
`define RST_BYTE          8'h00
`define RST_FUNC_SELECT   2'h0

// Function selector code for the two-wire slave
`define FUNC_TWO_WIRE     2'h2

// Phase codes
`define PH_IDLE           3'h0
`define PH_ADDR           3'h1
`define PH_RX             3'h2
`define PH_TX             3'h3
`define PH_MNACK          3'h4
`define PH_AA_OFF         3'h5

// Bit slots within a byte frame
`define SLOT_LAST_DATA    4'h7
`define SLOT_ACK          4'h8
`define SLOT_WAIT         4'hf  // Parked after a start; wraps to slot 0

// Bus responses
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

// ### pin_sync.v
`timescale 1ns/1ps
// Three-stage pin synchroniser; level moves only when stages two and
// three agree, which filters single-cycle glitches on the bus lines.
module pin_sync
(
  input  wire aclk,
  input  wire aresetn,
  input  wire pin_in,
  output reg  level_r
);

  reg s1_r;
  reg s2_r;
  reg s3_r;

  // Idle bus level is high, so reset to high
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s1_r    <= 1'b1;
      s2_r    <= 1'b1;
      s3_r    <= 1'b1;
      level_r <= 1'b1;
    end
    else
    begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r)
        level_r <= s3_r;
    end
  end

endmodule

// ### axil_front.v
`timescale 1ns/1ps
`include "twi_map.vh"
// AXI4-Lite slave front end: one write and one read at a time.
// Decode is done by the caller through wr_ok and rd_ok.
module axil_front
(
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output wire        wr_en,
  output reg  [11:0] wr_addr,
  output reg  [7:0]  wr_data,
  output reg         wr_lane0,
  input  wire        wr_ok,
  output reg  [11:0] rd_addr,
  input  wire        rd_ok,
  input  wire [7:0]  rd_data
);

  reg aw_held_r;
  reg w_held_r;
  reg ar_held_r;

  // Each channel is accepted alone; the pair is committed together
  assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_r && !s_axi_bvalid;
  assign s_axi_arready = !ar_held_r && !s_axi_rvalid;
  assign wr_en         = aw_held_r && w_held_r && !s_axi_bvalid;

  // Write channels and response
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_r    <= 1'b0;
      w_held_r     <= 1'b0;
      wr_addr      <= 12'h000;
      wr_data      <= 8'h00;
      wr_lane0     <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_r <= 1'b1;
        wr_addr   <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_r <= 1'b1;
        wr_data  <= s_axi_wdata[7:0];
        wr_lane0 <= s_axi_wstrb[0];
      end
      if (wr_en)
      begin
        aw_held_r    <= 1'b0;
        w_held_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Read channel: data registered one cycle after the address
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ar_held_r    <= 1'b0;
      rd_addr      <= 12'h000;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `RESP_OKAY;
    end
    else
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        ar_held_r <= 1'b1;
        rd_addr   <= s_axi_araddr;
      end
      else if (ar_held_r)
      begin
        ar_held_r    <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h000000, rd_data};
        s_axi_rresp  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// ### twi_slave_port.v
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "twi_map.vh"
// Slave-only two-wire port with an AXI4-Lite register window.
module twi_slave_port
(
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output wire [1:0]  s_axi_bresp,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        scl_in,
  input  wire        sda_in,
  output wire        sda_out,
  output wire        sda_oe
);

  // Register window signals
  wire        wr_en;
  wire [11:0] wr_addr;
  wire [7:0]  wr_data;
  wire        wr_lane0;
  wire [11:0] rd_addr;
  reg         wr_ok;
  reg         rd_ok;
  reg  [7:0]  rd_data;

  // Software state
  reg         port_enable_r;
  reg         event_flag_r;
  reg         general_call_hit_r;
  reg         accept_ack_r;
  reg  [6:0]  own_slave_address_r;
  reg         general_call_enable_r;
  reg  [7:0]  byte_buffer_r;
  reg  [1:0]  serial_function_select_r;

  // Bus-facing state
  wire        scl_lvl;
  wire        sda_lvl;
  reg         scl_prev_r;
  reg         sda_prev_r;
  reg  [2:0]  phase_r;
  reg  [3:0]  bit_cnt_r;
  reg  [7:0]  rx_shift_r;
  reg  [7:0]  tx_shift_r;
  reg         drive_low_r;
  reg         read_dir_r;
  reg         rx_nack_r;
  reg         master_ack_r;
  reg         selected_r;

  // Bus events seen on the filtered lines
  wire        active;
  wire        scl_rise;
  wire        scl_fall;
  wire        start_seen;
  wire        stop_seen;
  wire        addr_match;
  wire        gc_match;
  wire        hw_event;
  wire        hw_byte_rx;

  // Register access decode
  wire        wr_ctl;
  wire        wr_oa;
  wire        wr_buf;
  wire        wr_fsel;

  axil_front u_front
  (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wr_en         (wr_en),
    .wr_addr       (wr_addr),
    .wr_data       (wr_data),
    .wr_lane0      (wr_lane0),
    .wr_ok         (wr_ok),
    .rd_addr       (rd_addr),
    .rd_ok         (rd_ok),
    .rd_data       (rd_data)
  );

  // Both lines filtered alike so their relative timing is kept
  pin_sync u_scl_sync
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin_in  (scl_in),
    .level_r (scl_lvl)
  );

  pin_sync u_sda_sync
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin_in  (sda_in),
    .level_r (sda_lvl)
  );

  // Write and read decode; unmapped offsets answer with an error
  assign wr_ctl  = wr_en && wr_lane0 && (wr_addr[11:2] == `IDX_CONTROL);
  assign wr_oa   = wr_en && wr_lane0 &&
                   (wr_addr[11:2] == `IDX_OWN_ADDRESS);
  assign wr_buf  = wr_en && wr_lane0 &&
                   (wr_addr[11:2] == `IDX_BYTE_BUFFER);
  assign wr_fsel = wr_en && wr_lane0 &&
                   (wr_addr[11:2] == `IDX_FUNC_SELECT);

  always @*
  begin
    wr_ok = (wr_addr[1:0] == 2'h0) &&
            ((wr_addr[11:2] == `IDX_CONTROL) ||
             (wr_addr[11:2] == `IDX_OWN_ADDRESS) ||
             (wr_addr[11:2] == `IDX_BYTE_BUFFER) ||
             (wr_addr[11:2] == `IDX_FUNC_SELECT));
  end

  // Read mux; bit 5 of control is reserved and reads zero
  always @*
  begin
    rd_ok   = (rd_addr[1:0] == 2'h0);
    rd_data = 8'h00;
    case (rd_addr[11:2])
      `IDX_CONTROL:
        rd_data = {port_enable_r, event_flag_r, 1'b0,
                   general_call_hit_r, accept_ack_r, phase_r};
      `IDX_OWN_ADDRESS:
        rd_data = {own_slave_address_r, general_call_enable_r};
      `IDX_BYTE_BUFFER:
        rd_data = byte_buffer_r;
      `IDX_FUNC_SELECT:
        rd_data = {6'h00, serial_function_select_r};
      default:
        rd_ok = 1'b0;
    endcase
  end

  // Port answers only in two-wire personality and when enabled
  assign active     = port_enable_r &&
                      (serial_function_select_r == `FUNC_TWO_WIRE);
  assign scl_rise   = scl_lvl && !scl_prev_r;
  assign scl_fall   = !scl_lvl && scl_prev_r;
  // Start and stop are data edges while clock stays high
  assign start_seen = active && scl_lvl && scl_prev_r &&
                      sda_prev_r && !sda_lvl;
  assign stop_seen  = active && scl_lvl && scl_prev_r &&
                      !sda_prev_r && sda_lvl;
  assign addr_match = (rx_shift_r[7:1] == own_slave_address_r);
  // General call only with write direction
  assign gc_match   = general_call_enable_r &&
                      (rx_shift_r == 8'h00);
  assign hw_byte_rx = active && scl_fall && (phase_r == `PH_RX) &&
                      (bit_cnt_r == `SLOT_LAST_DATA);

  // Every condition that raises the event flag
  assign hw_event =
    (active && scl_fall && (bit_cnt_r == `SLOT_LAST_DATA) &&
     (((phase_r == `PH_ADDR) && (addr_match || gc_match)) ||
      (phase_r == `PH_RX) || (phase_r == `PH_TX))) ||
    (start_seen && selected_r) ||
    (stop_seen && selected_r);

  // Open-drain: only a low level is ever driven
  assign sda_out = 1'b0;
  assign sda_oe  = drive_low_r;

  // Software registers; a hardware set of the flag wins over clearing
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      port_enable_r            <= 1'b0;
      event_flag_r             <= 1'b0;
      accept_ack_r             <= 1'b0;
      own_slave_address_r      <= 7'h00;
      general_call_enable_r    <= 1'b0;
      serial_function_select_r <= `RST_FUNC_SELECT;
    end
    else
    begin
      if (wr_ctl)
      begin
        port_enable_r <= wr_data[`CTL_PORT_ENABLE];
        accept_ack_r  <= wr_data[`CTL_ACCEPT_ACK];
      end
      if (hw_event)
        event_flag_r <= 1'b1;
      else if (wr_ctl && !wr_data[`CTL_EVENT_FLAG])
        event_flag_r <= 1'b0;
      if (wr_oa)
      begin
        own_slave_address_r   <= wr_data[7:1];
        general_call_enable_r <= wr_data[`OA_GC_ENABLE];
      end
      if (wr_fsel)
        serial_function_select_r <= wr_data[1:0];
    end
  end

  // Byte buffer: received bytes take precedence over a software write
  always @(posedge aclk)
  begin
    if (!aresetn)
      byte_buffer_r <= `RST_BYTE;
    else if (hw_byte_rx)
      byte_buffer_r <= rx_shift_r;
    else if (wr_buf)
      byte_buffer_r <= wr_data;
  end

  // Slave protocol engine; it only follows the master's clock
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      scl_prev_r         <= 1'b1;
      sda_prev_r         <= 1'b1;
      phase_r            <= `PH_IDLE;
      bit_cnt_r          <= 4'h0;
      rx_shift_r         <= 8'h00;
      tx_shift_r         <= 8'h00;
      drive_low_r        <= 1'b0;
      read_dir_r         <= 1'b0;
      rx_nack_r          <= 1'b0;
      master_ack_r       <= 1'b0;
      selected_r         <= 1'b0;
      general_call_hit_r <= 1'b0;
    end
    else
    begin
      scl_prev_r <= scl_lvl;
      sda_prev_r <= sda_lvl;
      if (!active)
      begin
        // Disabling drops the bus at once
        phase_r            <= `PH_IDLE;
        drive_low_r        <= 1'b0;
        selected_r         <= 1'b0;
        general_call_hit_r <= 1'b0;
      end
      else if (stop_seen)
      begin
        phase_r            <= `PH_IDLE;
        drive_low_r        <= 1'b0;
        selected_r         <= 1'b0;
        general_call_hit_r <= 1'b0;
      end
      else if (start_seen)
      begin
        // Fresh start or restart both begin an address frame
        phase_r            <= `PH_ADDR;
        // The clock fall that closes the start is not a bit slot
        bit_cnt_r          <= `SLOT_WAIT;
        drive_low_r        <= 1'b0;
        selected_r         <= 1'b0;
        general_call_hit_r <= 1'b0;
      end
      else
      begin
        // Sample data on rising clock in the eight data slots
        if (scl_rise && (bit_cnt_r <= `SLOT_LAST_DATA))
          rx_shift_r <= {rx_shift_r[6:0], sda_lvl};
        // Master acknowledge sampled in the ninth slot
        if (scl_rise && (bit_cnt_r == `SLOT_ACK))
          master_ack_r <= sda_lvl;
        if (scl_fall)
        begin
          case (phase_r)
            `PH_ADDR:
            begin
              if (bit_cnt_r == `SLOT_LAST_DATA)
              begin
                bit_cnt_r <= `SLOT_ACK;
                if (addr_match || gc_match)
                begin
                  drive_low_r        <= 1'b1;
                  read_dir_r         <= rx_shift_r[0] && !gc_match;
                  selected_r         <= 1'b1;
                  general_call_hit_r <= gc_match && !addr_match;
                end
                else
                  phase_r <= `PH_IDLE;
              end
              else if (bit_cnt_r == `SLOT_ACK)
              begin
                bit_cnt_r   <= 4'h0;
                drive_low_r <= 1'b0;
                if (read_dir_r)
                begin
                  // First byte comes straight from the buffer
                  phase_r     <= `PH_TX;
                  tx_shift_r  <= byte_buffer_r;
                  drive_low_r <= !byte_buffer_r[7];
                end
                else
                  phase_r <= `PH_RX;
              end
              else
                bit_cnt_r <= bit_cnt_r + 4'h1;
            end
            `PH_RX:
            begin
              if (bit_cnt_r == `SLOT_LAST_DATA)
              begin
                bit_cnt_r   <= `SLOT_ACK;
                drive_low_r <= accept_ack_r;
                rx_nack_r   <= !accept_ack_r;
              end
              else if (bit_cnt_r == `SLOT_ACK)
              begin
                bit_cnt_r   <= 4'h0;
                drive_low_r <= 1'b0;
                if (rx_nack_r)
                begin
                  // Further master data is ignored until a start
                  phase_r    <= `PH_IDLE;
                  selected_r <= 1'b0;
                end
              end
              else
                bit_cnt_r <= bit_cnt_r + 4'h1;
            end
            `PH_TX:
            begin
              if (bit_cnt_r == `SLOT_LAST_DATA)
              begin
                // Release for the master's acknowledge slot
                bit_cnt_r   <= `SLOT_ACK;
                drive_low_r <= 1'b0;
              end
              else if (bit_cnt_r == `SLOT_ACK)
              begin
                bit_cnt_r <= 4'h0;
                if (master_ack_r)
                  phase_r <= `PH_MNACK;
                else if (!accept_ack_r)
                  phase_r <= `PH_AA_OFF;
                else
                begin
                  tx_shift_r  <= byte_buffer_r;
                  drive_low_r <= !byte_buffer_r[7];
                end
              end
              else
              begin
                bit_cnt_r   <= bit_cnt_r + 4'h1;
                tx_shift_r  <= {tx_shift_r[6:0], 1'b0};
                drive_low_r <= !tx_shift_r[6];
              end
            end
            `PH_MNACK, `PH_AA_OFF:
              drive_low_r <= 1'b0;
            default:
              drive_low_r <= 1'b0;
          endcase
        end
      end
    end
  end

endmodule

// ### twi_port_monitor.sv
`timescale 1ns/1ps
// Watches the register bus and the data pin of the two-wire port
module twi_port_monitor
(
  input wire        aclk,
  input wire        aresetn,
  input wire [11:0] s_axi_awaddr,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        scl_in,
  input wire        sda_out,
  input wire        sda_oe
);
  reg  [11:0] aw_q;
  reg  [11:0] ar_q;
  wire        aw_map;
  wire        ar_map;

  // Last accepted addresses, needed to judge the response codes
  always @(posedge aclk)
  begin
    if (s_axi_awvalid && s_axi_awready)
      aw_q <= s_axi_awaddr;
    if (s_axi_arvalid && s_axi_arready)
      ar_q <= s_axi_araddr;
  end

  // Only four aligned words answer without error
  assign aw_map = aw_q[1:0] == 2'h0 && aw_q >= 12'h294 && aw_q <= 12'h2a0;
  assign ar_map = ar_q[1:0] == 2'h0 && ar_q >= 12'h294 && ar_q <= 12'h2a0;

  default clocking mck @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  open_drain_a: assert property (sda_out == 1'b0)
    else $error("data pin output not low");
  oe_clock_low_a: assert property (
    $changed(sda_oe) |-> !scl_in && !$past(scl_in))
    else $error("data pin moved with clock high");
  slot_hold_a: assert property (
    sda_oe && $rose(scl_in) |=> sda_oe [*6])
    else $error("driven slot cut short");
  b_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  r_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  read_delay_a: assert property (
    s_axi_arvalid && s_axi_arready |=> !s_axi_arready ##1 s_axi_rvalid)
    else $error("read answer late");
  rdata_byte_a: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  bresp_code_a: assert property (
    $rose(s_axi_bvalid) |-> s_axi_bresp == (aw_map ? 2'h0 : 2'h2))
    else $error("write response code wrong");
  rresp_code_a: assert property (
    $rose(s_axi_rvalid) |-> s_axi_rresp == (ar_map ? 2'h0 : 2'h2))
    else $error("read response code wrong");
endmodule

// ### twi_master_model.sv
`timescale 1ns/1ps
// Behavioural bus master; clock is held low between frames, both lines released after a stop
module twi_master_model
#(
  parameter int H = 80
)
(
  input  wire  sda_wire,
  output logic scl,
  output logic sda_pull
);
  // Idle: clock high, data left to the pull-up
  initial
  begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  // Data set mid low phase, sampled mid high phase
  task automatic bit_slot(input logic b, output logic s);
    #(H/2);
    sda_pull = !b;
    #(H/2);
    scl = 1'b1;
    #(H/2);
    s = sda_wire;
    #(H/2);
    scl = 1'b0;
  endtask

  // Nine clocks a byte, the last for the acknowledge
  task automatic frame(input logic [8:0] tx, output logic [8:0] rx);
    #3; // Off the system clock edge
    for (int i = 8; i >= 0; i--)
      bit_slot(tx[i], rx[i]);
  endtask

  // Start or repeated start: data falls while clock high
  task automatic start;
    #3;
    #(H/2);
    sda_pull = 1'b0;
    #(H/2);
    scl = 1'b1;
    #H;
    sda_pull = 1'b1;
    #H;
    scl = 1'b0;
  endtask

  // Stop: data rises while clock high, then all released
  task automatic stop;
    #3;
    #(H/2);
    sda_pull = 1'b1;
    #(H/2);
    scl = 1'b1;
    #H;
    sda_pull = 1'b0;
    #H;
  endtask
endmodule

// ### testbench.sv
`timescale 1ns/1ps
`include "twi_map.vh"
module testbench;
  localparam logic [11:0] A_CTL = {`IDX_CONTROL, 2'h0};
  localparam logic [11:0] A_OWN = {`IDX_OWN_ADDRESS, 2'h0};
  localparam logic [11:0] A_BUF = {`IDX_BYTE_BUFFER, 2'h0};
  localparam logic [11:0] A_SEL = {`IDX_FUNC_SELECT, 2'h0};
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid;
  wire         s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire         scl_in, sda_in, sda_out, sda_oe, m_pull;
  int          n_fail = 0, checks_done = 0, seed;
  logic [6:0]  adr;
  logic [7:0]  x, y, v;
  logic        ak;

  twi_slave_port dut (.*);
  twi_master_model m (.sda_wire(sda_in), .scl(scl_in), .sda_pull(m_pull));

  // Pulled-up wire, low when either party pulls
  assign sda_in = !(sda_oe || m_pull);

  always #5 aclk = ~aclk;

  task automatic chk(input string nm, input logic [31:0] got, exp);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic give_verdict;
    if (n_fail == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Register write; valids dropped as each channel is taken
  task automatic wr(input logic [11:0] a, input logic [7:0] d,
                    input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int k = 0; k < 50 && s_axi_bvalid !== 1'b1; k++)
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    chk("bvalid", s_axi_bvalid, 1);
    s_axi_bready <= 1'b0;
    chk("bresp", s_axi_bresp, er);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] ex,
                    input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int k = 0; k < 50 && s_axi_rvalid !== 1'b1; k++)
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    chk("rvalid", s_axi_rvalid, 1);
    s_axi_rready <= 1'b0;
    chk("rdata", s_axi_rdata, ex);
    chk("rresp", s_axi_rresp, er);
  endtask

  // Expected control word from its fields
  function automatic logic [31:0] ctl(input logic f, g, a,
                                      input logic [2:0] p);
    return {24'h0, 1'b1, f, 1'b0, g, a, p};
  endfunction

  task automatic put(input logic [7:0] d, output logic a);
    logic [8:0] r;
    m.frame({d, 1'b1}, r);
    a = r[0];
    // Let the port act on the last clock fall before software looks
    repeat (8) @(posedge aclk);
  endtask

  task automatic get(input logic ma, output logic [7:0] d);
    logic [8:0] r;
    m.frame({8'hff, ma}, r);
    d = r[8:1];
    // Synchroniser delay: phase and reload follow the fall
    repeat (8) @(posedge aclk);
  endtask

  initial
  begin
    seed = $urandom(80731);
    adr = 7'($urandom_range(126, 1));
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(A_CTL, 0, 0);
    rd(A_OWN, 0, 0);
    rd(A_BUF, 0, 0);
    rd(A_SEL, 0, 0);
    rd(12'h004, 0, 2);
    wr(12'h004, 8'h5a, 2);
    // Selector walked through all codes, two-wire code last
    for (int f = 0; f < 4; f++)
    begin
      wr(A_SEL, 8'(2'(f + 3)), 0);
      wr(A_CTL, 8'h88, 0);
      wr(A_OWN, {adr, 1'b1}, 0);
      m.start;
      put({adr, 1'b0}, ak);
      chk("sel_ack", ak, f != 3);
      m.stop;
    end
    rd(A_CTL, ctl(1, 0, 1, 0), 0);
    wr(A_CTL, 8'h88, 0);
    // Write transfer with random bytes
    m.start;
    rd(A_CTL, ctl(0, 0, 1, 1), 0);
    put({adr, 1'b0}, ak);
    chk("addr_ack", ak, 0);
    rd(A_CTL, ctl(1, 0, 1, 2), 0);
    repeat (3)
    begin
      x = 8'($urandom);
      wr(A_CTL, 8'h88, 0);
      put(x, ak);
      chk("rx_ack", ak, 0);
      rd(A_BUF, x, 0);
      rd(A_CTL, ctl(1, 0, 1, 2), 0);
    end
    // Repeated start into a read; next byte queued meanwhile
    y = 8'($urandom);
    x = 8'($urandom);
    wr(A_BUF, y, 0);
    wr(A_CTL, 8'h88, 0);
    m.start;
    rd(A_CTL, ctl(1, 0, 1, 1), 0);
    put({adr, 1'b1}, ak);
    chk("rd_ack", ak, 0);
    wr(A_BUF, x, 0);
    get(1'b0, v);
    chk("tx0", v, y);
    get(1'b1, v);
    chk("tx1", v, x);
    rd(A_CTL, ctl(1, 0, 1, 4), 0);
    m.stop;
    rd(A_CTL, ctl(1, 0, 1, 0), 0);
    // Accept-ack dropped during transmission
    m.start;
    put({adr, 1'b1}, ak);
    wr(A_CTL, 8'h80, 0);
    get(1'b0, v);
    chk("tx_last", v, x);
    rd(A_CTL, ctl(1, 0, 0, 5), 0);
    m.stop;
    // Accept-ack dropped during reception
    wr(A_CTL, 8'h88, 0);
    m.start;
    put({adr, 1'b0}, ak);
    wr(A_CTL, 8'h80, 0);
    put(8'($urandom), ak);
    chk("rx_nack", ak, 1);
    rd(A_CTL, ctl(1, 0, 0, 0), 0);
    put(8'($urandom), ak);
    chk("rx_ignored", ak, 1);
    m.stop;
    // General call enabled, then disabled, then a stranger
    wr(A_CTL, 8'h88, 0);
    m.start;
    put(8'h00, ak);
    chk("gc_ack", ak, 0);
    rd(A_CTL, ctl(1, 1, 1, 2), 0);
    m.stop;
    rd(A_CTL, ctl(1, 0, 1, 0), 0);
    wr(A_OWN, {adr, 1'b0}, 0);
    m.start;
    put(8'h00, ak);
    chk("gc_off", ak, 1);
    m.start;
    put({~adr, 1'b0}, ak);
    chk("miss_ack", ak, 1);
    m.stop;
    give_verdict;
  end

  // Hang guard, far beyond the expected run length
  initial
  begin
    #500us;
    n_fail++;
    give_verdict;
  end
endmodule

bind twi_slave_port twi_port_monitor mon (.*);
